// ### design/tbef_formatter.sv
// Summary of operation
// R01: Loop mode stores change-of-flow, remembers last address
// R02: Only repeated source addresses are suppressed
// R03: Detail mode stores address, data, size, direction
// R04: Free and opcode fetch cycles are not traced
// R05: Detail entry is address line then data line
// R06: Line counter advances twice per detail entry
// R07: Byte data in low byte, high cleared
// R08: Word: lower-address byte in data byte one
// R09: Line is 4+8+8 bits; data line upper zero
// R10: Normal and loop share program counter layout
// R11: Detail bit 3 is size, 1 byte
// R12: Detail bit 2 is direction, 1 read
// R13: Detail bits 1:0 are address 17:16
// R14: Bit 3 marks source 0 or destination 1
// R15: Bit 2 marks vector, forces destination bit
// R16: Bits 1:0 hold program counter 17:16
// R17: Compressed mode stores every executed opcode counter
// R18: Low bits stored, full value on block change
// R19: Compressed row: two info bits, eighteen bits
// R20: Breakpoint latency may store a few extra opcodes
// R21: Circular 64 by 20 store, counter per line
// R22: Info code 0 base, 1-3 increments
// R23: New base on block change and first line
// R24: Loop holding register cleared when session arms
// R25: Three increments per row, partial row flushed
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tbef_map.svh"
module tbef_formatter
  import tbef_pkg::*;
#(
  parameter int LINES = `TBEF_LINES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Debug unit
  input wire logic armed,
  output logic [`TBEF_CNT_W-1:0] valid_line_counter,
  output logic buffer_wrapped,
  // Change-of-flow from the core
  input wire logic cof_valid,
  input wire logic cof_is_dest,
  input wire logic cof_is_vector,
  input wire logic [17:0] cof_pc,
  // Bus access from the core
  input wire logic acc_valid,
  input wire logic acc_free,
  input wire logic acc_fetch,
  input wire logic acc_byte,
  input wire logic acc_read,
  input wire logic [17:0] acc_addr,
  input wire logic [15:0] acc_data,
  // Executed opcode from the core
  input wire logic op_valid,
  input wire logic [17:0] op_pc
);
  localparam int PW = $clog2(LINES);
  localparam int LW = `TBEF_LINE_W;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Assemble a line from its upper field and two bytes
  function automatic logic [LW-1:0] mk_line(input logic [3:0] up, input logic [15:0] lo);
    mk_line = {up, lo};
  endfunction : mk_line

  // Assemble a compressed row from info code and eighteen bits
  function automatic logic [LW-1:0] mk_row(input logic [1:0] inf, input logic [17:0] bits);
    mk_row = {inf, bits};
  endfunction : mk_row

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [2:0] ctrl_reg, ctrl_next; // Mode and enable
  logic [PW-1:0] rdidx_reg, rdidx_next; // Readback line index
  logic ovr_reg, ovr_next; // Sticky detail overrun
  logic ack_reg, ack_next; // Bus answer phase
  logic [31:0] rdata_reg, rdata_next; // Read data
  logic armed_q_reg, armed_q_next; // Armed, one cycle late
  logic [PW-1:0] ptr_reg, ptr_next; // Next line to write
  logic [`TBEF_CNT_W-1:0] cnt_reg, cnt_next; // Valid lines
  logic wrap_reg, wrap_next; // Buffer rolled over
  logic lf_v_reg, lf_v_next; // Loop holding valid
  logic [17:0] lf_pc_reg, lf_pc_next; // Loop holding address
  tbef_dstate_t ds_reg, ds_next; // Detail sequencer
  logic [LW-1:0] dline_reg, dline_next; // Pending data line
  logic hv_reg, hv_next; // Held access valid
  logic [LW-1:0] ha_reg, ha_next; // Held address line
  logic [LW-1:0] hd_reg, hd_next; // Held data line
  logic cb_v_reg, cb_v_next; // Compressed base known
  logic [11:0] cb_blk_reg, cb_blk_next; // Base counter bits 17:6
  logic [1:0] cc_reg, cc_next; // Increments collected
  logic [5:0] cf_reg [3], cf_next [3]; // Increment fields
  logic cp_v_reg, cp_v_next; // Base row pending
  logic [LW-1:0] cp_line_reg, cp_line_next; // Pending base row
  tbef_mode_t mode;
  logic arm_rise, trace_on;
  logic wr_en;
  logic [LW-1:0] wr_line;
  logic [LW-1:0] rd_line;
  logic [LW-1:0] acc_aline, acc_dline;
  logic need_base, at_first;
  logic bus_req;

  assign mode = tbef_mode_t'(ctrl_reg[`TBEF_CTRL_MODE_LSB +: 2]);
  assign arm_rise = armed && !armed_q_reg;
  // Tracing lasts while armed and enabled; stops when the sequencer disarms or the enable bit clears R20
  assign trace_on = armed && !arm_rise && ctrl_reg[`TBEF_CTRL_EN_BIT];
  // Writing line 0 after rollover must carry a base row
  assign at_first = wrap_reg && (ptr_reg == '0);

  // Detail-mode line images
  assign acc_aline = mk_line({acc_byte, acc_read, acc_addr[17:16]}, acc_addr[15:0]); // R11 R12 R13
  assign acc_dline = mk_line(4'h0, acc_byte ? {8'h00, acc_data[7:0]} : acc_data); // R07 R08 R09

  // ****************************************************************
  // Trace storage
  // ****************************************************************
  tbef_line_ram #(
    .LINES(LINES),
    .WIDTH(LW)
  ) u_ram (
    .clk(clk),
    .wr_en(wr_en),
    .wr_idx(ptr_reg),
    .wr_line(wr_line),
    .rd_idx(rdidx_reg),
    .rd_line(rd_line)
  );

  // ****************************************************************
  // Entry formatting, next state
  // ****************************************************************
  always_comb
  begin
    wr_en = 1'b0;
    wr_line = '0;
    need_base = 1'b0;
    lf_v_next = lf_v_reg;
    lf_pc_next = lf_pc_reg;
    ds_next = ds_reg;
    dline_next = dline_reg;
    hv_next = hv_reg;
    ha_next = ha_reg;
    hd_next = hd_reg;
    cb_v_next = cb_v_reg;
    cb_blk_next = cb_blk_reg;
    cc_next = cc_reg;
    cf_next = cf_reg;
    cp_v_next = cp_v_reg;
    cp_line_next = cp_line_reg;
    ovr_next = ovr_reg;
    if (arm_rise)
    begin
      // New session: forget trace history; the sticky overrun flag is kept R24
      lf_v_next = 1'b0;
      ds_next = ds_addr;
      hv_next = 1'b0;
      cb_v_next = 1'b0;
      cc_next = 2'h0;
      cp_v_next = 1'b0;
    end
    else if (trace_on)
    begin
      case (mode)
        mode_normal, loop_filtered_mode:
        begin
          // Change-of-flow only; loop mode drops a repeated source R01 R02
          if (cof_valid && !(mode == loop_filtered_mode && !cof_is_dest
              && lf_v_reg && cof_pc == lf_pc_reg))
          begin
            wr_en = 1'b1;
            wr_line = mk_line({cof_is_dest || cof_is_vector, cof_is_vector,
                               cof_pc[17:16]}, cof_pc[15:0]); // R10 R14 R15 R16
            lf_v_next = 1'b1; // R01
            lf_pc_next = cof_pc;
          end
        end
        mode_detail:
        begin
          case (ds_reg)
            ds_addr:
            begin
              if (hv_reg)
              begin
                // Held access goes first, address line R05
                wr_en = 1'b1;
                wr_line = ha_reg;
                dline_next = hd_reg;
                ds_next = ds_data;
                hv_next = 1'b0;
                if (acc_valid && !acc_free && !acc_fetch) // R04
                begin
                  hv_next = 1'b1;
                  ha_next = acc_aline;
                  hd_next = acc_dline;
                end
              end
              else if (acc_valid && !acc_free && !acc_fetch) // R03 R04
              begin
                wr_en = 1'b1;
                wr_line = acc_aline; // R05
                dline_next = acc_dline;
                ds_next = ds_data;
              end
            end
            ds_data:
            begin
              // Data line follows its address line R05 R06
              wr_en = 1'b1;
              wr_line = dline_reg;
              ds_next = ds_addr;
              if (acc_valid && !acc_free && !acc_fetch) // R04
              begin
                if (hv_reg)
                begin
                  ovr_next = 1'b1; // No room: access lost
                end
                else
                begin
                  hv_next = 1'b1;
                  ha_next = acc_aline;
                  hd_next = acc_dline;
                end
              end
            end
            default:
            begin
              ds_next = ds_addr;
            end
          endcase
        end
        compressed_pc_mode:
        begin
          // Pending base row has priority for the write port
          if (cp_v_reg)
          begin
            wr_en = 1'b1;
            wr_line = cp_line_reg;
            cp_v_next = 1'b0;
          end
          if (op_valid) // R17
          begin
            need_base = !cb_v_reg || op_pc[17:6] != cb_blk_reg; // R23
            if (need_base)
            begin
              if (cc_reg != 2'h0)
              begin
                // Flush the partly filled row first R25
                wr_en = 1'b1;
                wr_line = mk_row(cc_reg, {cf_reg[2], cf_reg[1], cf_reg[0]}); // R22
                if (at_first)
                begin
                  wr_line = mk_row(`TBEF_INF_BASE, {cb_blk_reg, cf_reg[cc_reg - 2'h1]}); // R23
                end
                cp_v_next = 1'b1;
                cp_line_next = mk_row(`TBEF_INF_BASE, op_pc); // R18 R19
              end
              else if (cp_v_reg)
              begin
                cp_line_next = mk_row(`TBEF_INF_BASE, op_pc);
                cp_v_next = 1'b1;
              end
              else
              begin
                wr_en = 1'b1;
                wr_line = mk_row(`TBEF_INF_BASE, op_pc); // R22
              end
              cb_v_next = 1'b1;
              cb_blk_next = op_pc[17:6];
              cc_next = 2'h0;
              cf_next[0] = 6'h00;
              cf_next[1] = 6'h00;
              cf_next[2] = 6'h00;
            end
            else if (cc_reg == 2'h2)
            begin
              // Third increment completes the row R25
              wr_en = 1'b1;
              wr_line = mk_row(`TBEF_INF_THREE, {op_pc[5:0], cf_reg[1], cf_reg[0]}); // R22
              if (at_first)
              begin
                wr_line = mk_row(`TBEF_INF_BASE, op_pc); // R23
              end
              cc_next = 2'h0;
              cf_next[0] = 6'h00;
              cf_next[1] = 6'h00;
              cf_next[2] = 6'h00;
            end
            else
            begin
              // Collect into the next free field, field 0 first R18 R25
              cf_next[cc_reg] = op_pc[5:0];
              cc_next = cc_reg + 2'h1;
            end
          end
        end
        default:
        begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Line pointer and valid-line counter, next state
  // ****************************************************************
  always_comb
  begin
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    wrap_next = wrap_reg;
    if (arm_rise)
    begin
      ptr_next = '0;
      cnt_next = '0;
      wrap_next = 1'b0;
    end
    else if (wr_en)
    begin
      // Circular store, one count per line written until the count reaches LINES R06 R21
      ptr_next = ptr_reg + 1'b1;
      if (ptr_reg == PW'(LINES - 1))
      begin
        wrap_next = 1'b1;
      end
      if (cnt_reg != `TBEF_CNT_W'(LINES))
      begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Avalon-MM register access, next state
  // ****************************************************************
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_reg;

  always_comb
  begin
    ack_next = bus_req && !ack_reg;
    ctrl_next = ctrl_reg;
    rdidx_next = rdidx_reg;
    armed_q_next = armed;
    rdata_next = rdata_reg;
    // Read data is prepared in the wait cycle
    if (avs_read && !ack_reg)
    begin
      case (avs_address)
        `TBEF_REG_CTRL:
        begin
          rdata_next = {29'h0, ctrl_reg};
        end
        `TBEF_REG_STATUS:
        begin
          rdata_next = 32'h0;
          rdata_next[`TBEF_STAT_CNT_LSB +: `TBEF_CNT_W] = cnt_reg;
          rdata_next[`TBEF_STAT_PTR_LSB +: PW] = ptr_reg;
          rdata_next[`TBEF_STAT_WRAP_BIT] = wrap_reg;
          rdata_next[`TBEF_STAT_OVR_BIT] = ovr_reg;
        end
        `TBEF_REG_RDIDX:
        begin
          rdata_next = 32'h0;
          rdata_next[PW-1:0] = rdidx_reg;
        end
        `TBEF_REG_RDDATA:
        begin
          rdata_next = {12'h0, rd_line};
        end
        default:
        begin
          rdata_next = 32'h0;
        end
      endcase
    end
    // Writes take effect in the answer cycle
    if (avs_write && ack_reg)
    begin
      case (avs_address)
        `TBEF_REG_CTRL:
        begin
          ctrl_next = avs_writedata[2:0];
        end
        `TBEF_REG_RDIDX:
        begin
          rdidx_next = avs_writedata[PW-1:0];
        end
        default:
        begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `TBEF_CTRL_RST;
      rdidx_reg <= `TBEF_RDIDX_RST;
      ovr_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      armed_q_reg <= 1'b0;
      ptr_reg <= '0;
      cnt_reg <= '0;
      wrap_reg <= 1'b0;
      lf_v_reg <= 1'b0;
      lf_pc_reg <= 18'h0;
      ds_reg <= ds_addr;
      dline_reg <= '0;
      hv_reg <= 1'b0;
      ha_reg <= '0;
      hd_reg <= '0;
      cb_v_reg <= 1'b0;
      cb_blk_reg <= 12'h0;
      cc_reg <= 2'h0;
      cf_reg[0] <= 6'h00;
      cf_reg[1] <= 6'h00;
      cf_reg[2] <= 6'h00;
      cp_v_reg <= 1'b0;
      cp_line_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rdidx_reg <= rdidx_next;
      // Overrun: ovr_next carries the old value, so a status write never clears it
      ovr_reg <= ovr_next || (ovr_reg && !(avs_write && ack_reg
                 && avs_address == `TBEF_REG_STATUS && avs_writedata[`TBEF_STAT_OVR_BIT]));
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      armed_q_reg <= armed_q_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      wrap_reg <= wrap_next;
      lf_v_reg <= lf_v_next;
      lf_pc_reg <= lf_pc_next;
      ds_reg <= ds_next;
      dline_reg <= dline_next;
      hv_reg <= hv_next;
      ha_reg <= ha_next;
      hd_reg <= hd_next;
      cb_v_reg <= cb_v_next;
      cb_blk_reg <= cb_blk_next;
      cc_reg <= cc_next;
      cf_reg <= cf_next;
      cp_v_reg <= cp_v_next;
      cp_line_reg <= cp_line_next;
    end
  end

  // Outputs to the Avalon-MM port and the debug unit
  assign avs_readdata = rdata_reg;
  assign valid_line_counter = cnt_reg;
  assign buffer_wrapped = wrap_reg;
endmodule : tbef_formatter
`default_nettype wire

// ### design/tbef_map.svh
`ifndef TBEF_MAP_SVH
`define TBEF_MAP_SVH
// ****************************************************************
// Buffer geometry
// ****************************************************************
`define TBEF_LINES 64
`define TBEF_LINE_W 20
`define TBEF_CNT_W 7
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define TBEF_REG_CTRL 4'h0
`define TBEF_REG_STATUS 4'h4
`define TBEF_REG_RDIDX 4'h8
`define TBEF_REG_RDDATA 4'hC
// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define TBEF_CTRL_EN_BIT 0
`define TBEF_CTRL_MODE_LSB 1
`define TBEF_CTRL_RST 3'h0
`define TBEF_STAT_CNT_LSB 0
`define TBEF_STAT_PTR_LSB 8
`define TBEF_STAT_WRAP_BIT 16
`define TBEF_STAT_OVR_BIT 17
`define TBEF_RDIDX_RST 6'h00
// ****************************************************************
// Line layout
// ****************************************************************
`define TBEF_INF_BASE 2'h0
`define TBEF_INF_ONE 2'h1
`define TBEF_INF_TWO 2'h2
`define TBEF_INF_THREE 2'h3
`endif

// ### design/tbef_pkg.sv
// ****************************************************************
// Types shared by the trace entry formatter
// ****************************************************************
package tbef_pkg;
  // Trace mode select
  typedef enum logic [1:0] {
    mode_normal = 2'h0,
    loop_filtered_mode = 2'h1,
    mode_detail = 2'h2,
    compressed_pc_mode = 2'h3
  } tbef_mode_t;
  // Detail-mode line sequencer
  typedef enum logic {
    ds_addr = 1'b0,
    ds_data = 1'b1
  } tbef_dstate_t;
endpackage : tbef_pkg

// ### design/tbef_line_ram.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Trace line storage, flip-flop array, one write and one read port
// ****************************************************************
module tbef_line_ram #(
  parameter int LINES = 64,
  parameter int WIDTH = 20
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(LINES)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_line,
  // Read port
  input wire logic [$clog2(LINES)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_line
);
  // Contents are deliberately not reset
  logic [WIDTH-1:0] mem [LINES];

  // Store one line per cycle
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_idx] <= wr_line;
    end
  end

  // Read by index
  assign rd_line = mem[rd_idx];
endmodule : tbef_line_ram
`default_nettype wire

// ### sim/tbef_formatter_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "tbef_map.svh"
// ****
// Port checker
// ****
module tbef_formatter_checker
  import tbef_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Session
  input wire logic armed,
  input wire logic [`TBEF_CNT_W-1:0] valid_line_counter,
  input wire logic buffer_wrapped,
  // Core events
  input wire logic cof_valid,
  input wire logic acc_valid,
  input wire logic acc_free,
  input wire logic acc_fetch
);
  logic [2:0] ctrl_reg; // Control copy
  logic [2:0] ctrl_next; // Next copy
  // Track control writes
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (avs_write && !avs_waitrequest && avs_address == 4'h0)
    begin
      ctrl_next = avs_writedata[2:0];
    end
  end
  // Register the copy
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= 3'h0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("late answer");
  AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("idle wait");
  AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == 4'h1
    |-> avs_readdata == 32'h0) else $error("unmapped read");
  AST_CNT_SAT: assert property (valid_line_counter <= 7'h40)
    else $error("count over depth");
  AST_ARM_CLEAR: assert property ($rose(armed) |=> valid_line_counter == 7'h00 && !buffer_wrapped)
    else $error("no session clear");
  AST_UNARMED_HOLD: assert property (!armed |=> $stable(valid_line_counter))
    else $error("stored unarmed");
  AST_NORMAL_ONE: assert property (armed && $past(armed) && ctrl_reg == 3'h1 && cof_valid
    && valid_line_counter < 7'h40 |=> valid_line_counter == $past(valid_line_counter) + 7'h01)
    else $error("flow not one line");
  AST_DETAIL_TWO: assert property (armed && $past(armed) && ctrl_reg == {mode_detail, 1'b1}
    && acc_valid && !acc_free && !acc_fetch && !$past(acc_valid) && valid_line_counter < 7'h3F
    |=> ##1 valid_line_counter == $past(valid_line_counter, 2) + 7'h02)
    else $error("detail not two lines");
  AST_SKIP_IDLE: assert property (ctrl_reg == {mode_detail, 1'b1} && acc_valid
    && (acc_free || acc_fetch) && !$past(acc_valid) |=> $stable(valid_line_counter))
    else $error("idle cycle stored");
endmodule : tbef_formatter_checker
bind tbef_formatter tbef_formatter_checker u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .armed(armed), .valid_line_counter(valid_line_counter),
  .buffer_wrapped(buffer_wrapped), .cof_valid(cof_valid), .acc_valid(acc_valid),
  .acc_free(acc_free), .acc_fetch(acc_fetch));
`default_nettype wire

// ### sim/tbef_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Core activity source
// ****
module tbef_core_model (
  // Clock
  input wire logic clk,
  // Change of flow
  output logic cof_valid,
  output logic cof_is_dest,
  output logic cof_is_vector,
  output logic [17:0] cof_pc,
  // Bus access
  output logic acc_valid,
  output logic acc_free,
  output logic acc_fetch,
  output logic acc_byte,
  output logic acc_read,
  output logic [17:0] acc_addr,
  output logic [15:0] acc_data,
  // Executed opcode
  output logic op_valid,
  output logic [17:0] op_pc
);
  // Quiet start
  initial
  begin
    {cof_valid, cof_is_dest, cof_is_vector, cof_pc, op_valid, op_pc} = '0;
    {acc_valid, acc_free, acc_fetch, acc_byte, acc_read, acc_addr, acc_data} = '0;
  end
  // Idle cycles, stale buses scrambled
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk);
      {cof_valid, acc_valid, op_valid} <= 3'h0;
      cof_pc <= ~cof_pc;
      acc_addr <= ~acc_addr;
      acc_data <= ~acc_data;
      op_pc <= ~op_pc;
    end
  endtask : quiet
  // One change of flow
  task automatic flow(input logic dest, input logic vec, input logic [17:0] pc);
    @(posedge clk);
    {cof_valid, cof_is_dest, cof_is_vector, cof_pc} <= {1'b1, dest, vec, pc};
  endtask : flow
  // One core bus cycle
  task automatic access(input logic [3:0] kind, input logic [17:0] adr, input logic [15:0] dat);
    @(posedge clk);
    {acc_valid, acc_free, acc_fetch, acc_byte, acc_read} <= {1'b1, kind};
    {acc_addr, acc_data} <= {adr, dat};
  endtask : access
  // One executed opcode
  task automatic opcode(input logic [17:0] pc);
    @(posedge clk);
    {op_valid, op_pc} <= {1'b1, pc};
  endtask : opcode
endmodule : tbef_core_model
`default_nettype wire

// ### sim/tbef_formatter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tbef_map.svh"
// ****
// Entry formatter bench
// ****
module tbef_formatter_tb_top
  import tbef_pkg::*;
;
  logic clk, rst, armed, buffer_wrapped; // Clock, reset, session
  logic [3:0] avs_address; // Bus address
  logic avs_read, avs_write, avs_waitrequest; // Bus handshake
  logic [31:0] avs_writedata, avs_readdata, rd; // Bus data
  logic [`TBEF_CNT_W-1:0] valid_line_counter; // Stored lines
  logic cof_valid, cof_is_dest, cof_is_vector, acc_valid, acc_free, acc_fetch; // Core strobes
  logic acc_byte, acc_read, op_valid; // Core qualifiers
  logic [17:0] cof_pc, acc_addr, op_pc; // Core addresses
  logic [15:0] acc_data; // Core data
  int n_mismatch = 0, tests_run = 0; // Counters
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  tbef_formatter DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .armed(armed),
    .valid_line_counter(valid_line_counter), .buffer_wrapped(buffer_wrapped),
    .cof_valid(cof_valid), .cof_is_dest(cof_is_dest), .cof_is_vector(cof_is_vector),
    .cof_pc(cof_pc), .acc_valid(acc_valid), .acc_free(acc_free), .acc_fetch(acc_fetch),
    .acc_byte(acc_byte), .acc_read(acc_read), .acc_addr(acc_addr), .acc_data(acc_data),
    .op_valid(op_valid), .op_pc(op_pc));
  tbef_core_model CORE (.clk(clk), .cof_valid(cof_valid), .cof_is_dest(cof_is_dest),
    .cof_is_vector(cof_is_vector), .cof_pc(cof_pc), .acc_valid(acc_valid),
    .acc_free(acc_free), .acc_fetch(acc_fetch), .acc_byte(acc_byte), .acc_read(acc_read),
    .acc_addr(acc_addr), .acc_data(acc_data), .op_valid(op_valid), .op_pc(op_pc));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One held bus transfer
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, adr, wd};
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) chk("bus answer", 32'h0, 32'h1);
    {avs_write, avs_read} <= 2'h0;
  endtask : bus
  // Start a session
  task automatic arm(input tbef_mode_t m);
    bus(1'b1, `TBEF_REG_CTRL, {29'h0, m, 1'b1});
    @(posedge clk);
    armed <= 1'b1;
  endtask : arm
  // End session, check lines
  task automatic lines(input int n, input logic [79:0] e);
    CORE.quiet(3);
    @(posedge clk);
    armed <= 1'b0;
    chk("line count", n, {25'h0, valid_line_counter});
    for (int i = 0; i < n; i++)
    begin
      bus(1'b1, `TBEF_REG_RDIDX, i);
      bus(1'b0, `TBEF_REG_RDDATA, 32'h0);
      chk("trace line", {12'h0, e[i*20 +: 20]}, {12'h0, rd[19:0]});
    end
  endtask : lines
  // Reset values, unmapped
  task automatic t_regs;
    bus(1'b0, `TBEF_REG_CTRL, 32'h0);
    chk("control", 32'h0, rd);
    bus(1'b0, `TBEF_REG_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    bus(1'b1, 4'h1, 32'hFFFFFFFF);
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, `TBEF_REG_CTRL, 32'h0);
    chk("control", 32'h0, rd);
  endtask : t_regs
  // Source, destination and vector lines
  task automatic t_normal;
    arm(mode_normal);
    CORE.flow(1'b0, 1'b0, 18'h21234);
    CORE.flow(1'b1, 1'b0, 18'h1ABCD);
    CORE.flow(1'b0, 1'b1, 18'h0FFF2);
    lines(3, {20'h0, 20'hCFFF2, 20'h9ABCD, 20'h21234});
  endtask : t_normal
  // Loop filtering
  task automatic t_loop;
    arm(loop_filtered_mode);
    CORE.flow(1'b0, 1'b0, 18'h00100);
    CORE.flow(1'b0, 1'b0, 18'h00100);
    CORE.flow(1'b1, 1'b0, 18'h00200);
    CORE.flow(1'b1, 1'b0, 18'h00200);
    CORE.flow(1'b0, 1'b0, 18'h00100);
    lines(4, {20'h00100, 20'h80200, 20'h80200, 20'h00100});
    arm(loop_filtered_mode);
    CORE.flow(1'b0, 1'b0, 18'h00100);
    lines(1, {60'h0, 20'h00100});
  endtask : t_loop
  // Detail entries
  task automatic t_detail;
    arm(mode_detail);
    CORE.access(4'h3, 18'h30010, 16'hEE55);
    CORE.quiet(2);
    CORE.access(4'h0, 18'h04000, 16'hA1B2);
    CORE.quiet(2);
    CORE.access(4'h8, 18'h05000, 16'h1111);
    CORE.quiet(2);
    CORE.access(4'h4, 18'h06000, 16'h2222);
    lines(4, {20'h0A1B2, 20'h04000, 20'h00055, 20'hF0010});
  endtask : t_detail
  // Compressed rows
  task automatic t_comp;
    arm(compressed_pc_mode);
    CORE.opcode(18'h00040);
    CORE.opcode(18'h00041);
    CORE.opcode(18'h00042);
    CORE.opcode(18'h00043);
    CORE.opcode(18'h00044);
    CORE.opcode(18'h10080);
    lines(4, {20'h10080, 20'h40004, 20'hC3081, 20'h00040});
  endtask : t_comp
  // Verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // Main sequence
  initial
  begin
    {rst, armed, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 39'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_normal;
    t_loop;
    t_detail;
    t_comp;
    conclude;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("unexpected watchdog expected 0 seen 1");
    conclude;
  end
endmodule : tbef_formatter_tb_top
`default_nettype wire
